// File: dv/pll_clock_synthesizer_control_tb.sv
// self-checking bench for the synthesizer and its controller
`timescale 1ns/100ps
module pll_clock_synthesizer_control_tb;
  import pll_synth_pkg::*;
  // ----------------------------------------
  // signals, instances and tasks
  // ----------------------------------------
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  refClk   = 4'h0;
  logic [3:0]  refCnt   = 4'h0;
  logic [7:0]  mult     = DEF_MULT;
  logic [7:0]  post     = DEF_POST;
  logic [31:0] rd;
  logic        err;
  logic        irqA;
  logic [4:0]  last;
  logic [4:0]  seen;
  logic [1:0]  fbBad;
  logic [1:0]  base;
  int          errorCnt = 0;
  int          comparisons = 0;

  pll_link_if i_pll_link_if();
  pll_synth_device i_pll_synth_device(.core_clk(core_clk), .rst_n(rst_n), .refClockInputs(refClk),
    .preDivide(DEF_PRE), .multiply(mult), .postDivide(post), .feedbackDivide(DEF_FBK),
    .outDivide(DEF_OUTDIV), .link(i_pll_link_if));
  pll_synth_controller i_pll_synth_controller(.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(i_pll_link_if));
  pll_synth_assertions i_pll_synth_assertions(.core_clk(core_clk), .rst_n(rst_n),
    .refClockChoice(i_pll_link_if.refClockChoice), .pllResetLow(i_pll_link_if.pllResetLow),
    .phaseValue(i_pll_link_if.phaseValue), .phaseSelect(i_pll_link_if.phaseSelect),
    .phaseApplyStrobe(i_pll_link_if.phaseApplyStrobe), .lockIndicator(i_pll_link_if.lockIndicator));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // references toggle every four cycles, two of them inverted
  always @(posedge core_clk) begin
    refCnt <= refCnt + 4'h1;
    refClk <= {4{refCnt[2]}} ^ 4'h5;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready wait", 32'h1, 32'(n));
  endtask

  task automatic waitLock(input logic exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((rd[1] !== exp || rd[2] !== 1'b0) && n < 100);
    check("lock", {31'h0, exp}, {31'h0, i_pll_link_if.lockIndicator});
  endtask

  task automatic phaseShift(input logic [2:0] v, input logic [4:0] s);
    int n;
    n = 0;
    apb(1'b1, OFS_PHASE, {15'h0, 1'b1, 7'h0, s, 1'b0, v});
    while (i_pll_link_if.phaseApplyStrobe !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    check("phase value", {29'h0, v}, {29'h0, i_pll_link_if.phaseValue});
    check("phase select", {27'h0, s}, {27'h0, i_pll_link_if.phaseSelect});
    check("phase strobe", 32'h1, {31'h0, i_pll_link_if.phaseApplyStrobe});
  endtask

  task automatic finishTest();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errorCnt++;
    finishTest();
  end

  initial begin
    void'($urandom(32'ha1da));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_MASK, 32'h0);
    check("mask reset", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    waitLock(1'b1);
    apb(1'b0, OFS_IRQ, 32'h0);
    check("lock event", 32'h1, rd & 32'h1);
    base = 2'($urandom);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_CTRL, {26'h0, base + 2'(k), 4'h1});
      apb(1'b0, OFS_STATUS, 32'h0);
      check("lock in reset", 32'h0, {31'h0, i_pll_link_if.lockIndicator});
      waitLock(1'b1);
      check("ref choice", {30'h0, base + 2'(k)}, {30'h0, i_pll_link_if.refClockChoice});
    end
    for (int v = 0; v < 8; v++) begin
      phaseShift(3'(v), 5'($urandom_range(31, 1)));
    end
    phaseShift(3'h7, 5'h1F);
    apb(1'b0, OFS_IRQ, 32'h0);
    check("phase event", 32'h4, rd & 32'h4);
    last = i_pll_link_if.synthClocks;
    seen = 5'h00;
    fbBad = 2'b00;
    repeat (200) begin
      @(posedge core_clk);
      seen = seen | (i_pll_link_if.synthClocks ^ last);
      fbBad[0] = fbBad[0] | (i_pll_link_if.coreFeedbackIn ^ last[0]);
      fbBad[1] = fbBad[1] | (i_pll_link_if.padFeedbackIn ^ last[0]);
      last = i_pll_link_if.synthClocks;
    end
    check("outputs toggle", 32'h1F, {27'h0, seen});
    check("core feedback", 32'h0, {31'h0, fbBad[0]});
    check("pad feedback", 32'h0, {31'h0, fbBad[1]});
    apb(1'b1, OFS_MASK, 32'h7);
    apb(1'b0, OFS_MASK, 32'h0);
    check("mask rw", 32'h7, rd);
    irqA = irq;
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b0, OFS_MASK, 32'h0);
    check("irq follows mask", 32'h1, {31'h0, irqA ^ irq});
    check("irq unmasked", 32'h1, {31'h0, irqA});
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h7);
    apb(1'b1, OFS_IRQ, 32'h7);
    apb(1'b0, OFS_IRQ, 32'h0);
    check("irq clear", 32'h0, rd);
    check("irq low", 32'h0, {31'h0, irq});
    mult <= 8'h10;
    post <= 8'h10;
    waitLock(1'b0);
    mult <= DEF_MULT;
    post <= DEF_POST;
    apb(1'b1, OFS_CTRL, 32'h1);
    waitLock(1'b1);
    apb(1'b0, OFS_IRQ, 32'h0);
    check("unlock event", 32'h2, rd & 32'h2);
    finishTest();
  end
endmodule

// File: dv/pll_synth_assertions.sv
// concurrent checks on the link between synthesizer and controller
`timescale 1ns/100ps
module pll_synth_assertions
  import pll_synth_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic [SEL_WIDTH-1:0]   refClockChoice,
  input wire logic                   pllResetLow,
  input wire logic [PHASE_WIDTH-1:0] phaseValue,
  input wire logic [OUT_COUNT-1:0]   phaseSelect,
  input wire logic                   phaseApplyStrobe,
  input wire logic                   lockIndicator
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  localparam int LOCK_MIN = 60;
  logic [7:0] runCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the synthesizer left reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      runCnt <= 8'h00;
    else if (!pllResetLow)
      runCnt <= 8'h00;
    else if (runCnt != 8'hFF)
      runCnt <= runCnt + 8'h01;
  end
  property p_reset_hold;
    $rose(pllResetLow) |-> !$past(pllResetLow, 2);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset pulse shorter than 10 ns");
  property p_ref_change;
    $changed(refClockChoice) |-> !pllResetLow;
  endproperty
  a_ref_change: assert property (p_ref_change) else $error("reference changed out of reset");
  property p_lock_reset;
    !pllResetLow |=> !lockIndicator;
  endproperty
  a_lock_reset: assert property (p_lock_reset) else $error("lock high while in reset");
  property p_lock_wait;
    $rose(lockIndicator) |-> runCnt >= LOCK_MIN;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock rose too soon after reset");
  property p_lock_run;
    $rose(lockIndicator) |-> pllResetLow && $past(pllResetLow);
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("lock rose without running loop");
  property p_reset_release;
    $fell(pllResetLow) |-> ##[1:8] pllResetLow;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset never released");
  property p_strobe_pulse;
    phaseApplyStrobe |=> !phaseApplyStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("phase strobe longer than a cycle");
  property p_phase_stable;
    phaseApplyStrobe |-> $stable(phaseValue) && $stable(phaseSelect);
  endproperty
  a_phase_stable: assert property (p_phase_stable) else $error("phase fields moved under strobe");
endmodule

// File: rtl/pll_link_if.sv
// signals between the synthesizer and its controlling fabric logic
`timescale 1ns/100ps
interface pll_link_if;
  import pll_synth_pkg::*;
  logic [SEL_WIDTH-1:0]   refClockChoice;
  logic                   pllResetLow;
  logic                   coreFeedbackIn;
  logic                   padFeedbackIn;
  logic [PHASE_WIDTH-1:0] phaseValue;
  logic [OUT_COUNT-1:0]   phaseSelect;
  logic                   phaseApplyStrobe;
  logic                   lockIndicator;
  logic [OUT_COUNT-1:0]   synthClocks;

  modport device (input refClockChoice, pllResetLow, coreFeedbackIn, padFeedbackIn,
                  phaseValue, phaseSelect, phaseApplyStrobe,
                  output lockIndicator, synthClocks);
  modport controller (output refClockChoice, pllResetLow, coreFeedbackIn, padFeedbackIn,
                      phaseValue, phaseSelect, phaseApplyStrobe,
                      input lockIndicator, synthClocks);
endinterface

// File: rtl/pll_synth_controller.sv
// fabric-side controller: APB registers, reset sequencing, phase shift and lock interrupts
`timescale 1ns/100ps
module pll_synth_controller
  import pll_synth_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  pll_link_if.controller   link
);
  import pll_synth_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [SEL_WIDTH-1:0]   selReq;
  logic [PHASE_WIDTH-1:0] phaseReq;
  logic [OUT_COUNT-1:0]   phaseSelReq;
  logic [EV_WIDTH-1:0]    irqStatus;
  logic [EV_WIDTH-1:0]    irqMask;
  logic                   startReq;
  logic                   phaseReq_go;
  logic                   wrEn;
  logic                   busy;
  logic                   lockPrev;
  logic [EV_WIDTH-1:0]    events;
  ctl_state_e             state;
  logic [7:0]             holdCount;

  assign wrEn = psel && penable && pwrite;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selReq      <= '0;
      phaseReq    <= '0;
      phaseSelReq <= '0;
      irqMask     <= '0;
      startReq    <= 1'b0;
      phaseReq_go <= 1'b0;
    end else begin
      startReq    <= 1'b0;
      phaseReq_go <= 1'b0;
      if (wrEn && paddr == OFS_CTRL) begin
        selReq   <= pwdata[CTRL_SEL_LO +: SEL_WIDTH];
        startReq <= pwdata[CTRL_START];
      end
      if (wrEn && paddr == OFS_PHASE) begin
        phaseReq    <= pwdata[PH_VAL_LO +: PHASE_WIDTH];
        phaseSelReq <= pwdata[PH_SEL_LO +: OUT_COUNT];
        phaseReq_go <= pwdata[PH_GO];
      end
      if (wrEn && paddr == OFS_MASK) begin
        irqMask <= pwdata[EV_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // sequencer: reset pulse around reference change, phase strobe
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                 <= CTL_RESET;
      holdCount             <= 8'h00;
      link.pllResetLow      <= 1'b0;
      link.refClockChoice   <= '0;
      link.phaseValue       <= '0;
      link.phaseSelect      <= '0;
      link.phaseApplyStrobe <= 1'b0;
    end else begin
      link.phaseApplyStrobe <= 1'b0;
      unique case (state)
        CTL_IDLE: begin
          if (startReq) begin
            state            <= CTL_RESET;
            holdCount        <= 8'h00;
            link.pllResetLow <= 1'b0;
          end else if (phaseReq_go) begin
            state                 <= CTL_SHIFT;
            link.phaseValue       <= phaseReq;
            link.phaseSelect      <= phaseSelReq;
          end
        end
        CTL_RESET: begin
          // choice moves only once reset has been seen low for a cycle
          if (holdCount == 8'h00) begin
            link.refClockChoice <= selReq; // [RULE2]
          end
          if (holdCount >= 8'(RESET_MIN_CYC)) begin // [RULE4]
            state            <= CTL_IDLE;
            link.pllResetLow <= 1'b1;
          end else begin
            holdCount <= holdCount + 8'h01;
          end
        end
        CTL_SHIFT: begin
          link.phaseApplyStrobe <= 1'b1;
          state                 <= CTL_IDLE;
        end
        default: state <= CTL_IDLE;
      endcase
    end
  end

  // feedback inputs: core feedback loops the first output back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.coreFeedbackIn <= 1'b0;
      link.padFeedbackIn  <= 1'b0;
    end else begin
      link.coreFeedbackIn <= link.synthClocks[0]; // [RULE13]
      link.padFeedbackIn  <= link.synthClocks[0]; // [RULE14]
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign busy   = (state != CTL_IDLE);
  assign events = {link.phaseApplyStrobe, lockPrev & ~link.lockIndicator, ~lockPrev & link.lockIndicator};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockPrev  <= 1'b0;
      irqStatus <= '0;
      irq       <= 1'b0;
    end else begin
      lockPrev  <= link.lockIndicator;
      irqStatus <= (irqStatus & ~((wrEn && paddr == OFS_IRQ) ? pwdata[EV_WIDTH-1:0] : '0)) | events;
      irq       <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------
  // apb read side, no wait states
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {OFS_CTRL, OFS_PHASE, OFS_STATUS, OFS_IRQ, OFS_MASK});
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFS_CTRL:   prdata <= 32'({selReq, 4'h0});
          OFS_PHASE:  prdata <= 32'({phaseSelReq, 1'b0, phaseReq});
          OFS_STATUS: prdata <= 32'({busy, link.lockIndicator, link.pllResetLow});
          OFS_IRQ:    prdata <= 32'(irqStatus);
          OFS_MASK:   prdata <= 32'(irqMask);
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// File: rtl/pll_synth_device.sv
// behavioural clock synthesizer: reference mux, counters, output dividers, phase shift, lock
//
// How it works
// RULE1: four references, two-bit choice picks one
// RULE2: user holds reset while changing reference
// RULE3: reset low resets, high starts locking
// RULE4: user holds reset at least 10 ns
// RULE5: lock rises on lock, falls on loss
// RULE6: pre, multiplier, post and output counters
// RULE7: fout = fin*M*Cfbk/(N*C), product <=255
// RULE8: five outputs, own divider and phase; here all five divide by the one shared outDivide value
// RULE9: first output at most 4x reference
// RULE10: phase code is half post-divider cycles
// RULE11: five-bit select picks shifted outputs
// RULE12: strobe high applies phase, else unchanged
// RULE13: core feedback wired to clock output
// RULE14: pad feedback wired to clock output
// RULE15: cascade at most two synthesizers
// RULE16: lock low in reset until relocked
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module pll_synth_device
  import pll_synth_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [REF_COUNT-1:0] refClockInputs,
  input  wire logic [7:0]           preDivide,
  input  wire logic [7:0]           multiply,
  input  wire logic [7:0]           postDivide,
  input  wire logic [7:0]           feedbackDivide,
  input  wire logic [7:0]           outDivide,
  pll_link_if.device                link
);
  import pll_synth_pkg::*;

  // ----------------------------------------
  // reference selection and edge detect
  // ----------------------------------------
  logic       refSel;
  logic       refPrev;
  logic       refEdge;
  logic [7:0] preCount;
  logic       pfdTick;
  logic       cfgLegal;
  logic [23:0] product;

  assign refSel   = refClockInputs[link.refClockChoice]; // [RULE1]
  assign refEdge  = refSel & ~refPrev;
  assign product  = 24'(multiply) * 24'(postDivide) * 24'(feedbackDivide);
  assign cfgLegal = (product <= 24'(PRODUCT_LIMIT)) && (preDivide != 8'h00) && (multiply != 8'h00); // [RULE7]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refPrev <= 1'b0;
    end else begin
      refPrev <= refSel;
    end
  end

  // pre-divider: one detector tick every N reference edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCount <= 8'h00;
      pfdTick  <= 1'b0;
    end else if (!link.pllResetLow) begin // [RULE3]
      preCount <= 8'h00;
      pfdTick  <= 1'b0;
    end else begin
      pfdTick <= 1'b0;
      if (refEdge) begin
        if (preCount + 8'h01 >= preDivide) begin // [RULE6]
          preCount <= 8'h00;
          pfdTick  <= 1'b1;
        end else begin
          preCount <= preCount + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // lock acquisition
  // ----------------------------------------
  logic [7:0] lockCount;
  logic [7:0] idleCount;
  logic       lock_indicator;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockCount <= 8'h00;
      idleCount <= 8'h00;
      lock_indicator    <= 1'b0;
    end else if (!link.pllResetLow) begin
      lockCount <= 8'h00;
      idleCount <= 8'h00;
      lock_indicator    <= 1'b0; // [RULE16]
    end else begin
      idleCount <= pfdTick ? 8'h00 : ((idleCount == 8'hFF) ? idleCount : idleCount + 8'h01);
      if (!cfgLegal || idleCount == 8'hFF) begin
        lockCount <= 8'h00;
        lock_indicator    <= 1'b0; // [RULE5]
      end else if (lockCount >= 8'(LOCK_WAIT_CYC)) begin
        lock_indicator    <= 1'b1; // [RULE5]
      end else begin
        lockCount <= lockCount + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.lockIndicator <= 1'b0;
    end else begin
      link.lockIndicator <= lock_indicator & link.pllResetLow; // [RULE16]
    end
  end

  // ----------------------------------------
  // synthesized clock: vco phase ticks from M*Cfbk/N, post-divided by O
  // ----------------------------------------
  logic [15:0] vcoAcc;
  logic        pllTick;
  logic [7:0]  postCount;
  logic        halfTick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcoAcc    <= 16'h0000;
      postCount <= 8'h00;
      halfTick  <= 1'b0;
    end else if (!lock_indicator) begin
      vcoAcc    <= 16'h0000;
      postCount <= 8'h00;
      halfTick  <= 1'b0;
    end else begin
      halfTick <= 1'b0;
      if (pllTick) begin
        if (postCount + 8'h01 >= postDivide) begin // [RULE6]
          postCount <= 8'h00;
          halfTick  <= 1'b1;
        end else begin
          postCount <= postCount + 8'h01;
        end
      end
      vcoAcc <= pllTick ? 16'h0000 : vcoAcc + 16'(multiply) * 16'(feedbackDivide);
    end
  end
  assign pllTick = (vcoAcc >= {8'h00, preDivide} * 16'h0020); // [RULE7]

  // ----------------------------------------
  // per-output divider and phase shifter
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < OUT_COUNT; g++) begin : gOut
      logic [PHASE_WIDTH-1:0] phase;
      logic [7:0]             divCount;
      logic [PHASE_WIDTH-1:0] delayCount;
      logic                   level;

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          phase <= '0;
        end else if (link.phaseApplyStrobe && link.phaseSelect[g]) begin // [RULE11] [RULE12]
          phase <= link.phaseValue;
        end
      end

      // toggles once divCount, stepping by two per post-divider tick, reaches outDivide; phase code delays the start
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          divCount   <= 8'h00;
          delayCount <= '0;
          level      <= 1'b0;
        end else if (!lock_indicator || (link.phaseApplyStrobe && link.phaseSelect[g])) begin
          divCount   <= 8'h00;
          delayCount <= '0;
          level      <= 1'b0;
        end else if (halfTick) begin
          if (delayCount < phase) begin
            delayCount <= delayCount + 1'b1; // [RULE10]
          end else if (divCount + 8'h02 >= outDivide) begin // [RULE8]
            divCount <= 8'h00;
            level    <= ~level;
          end else begin
            divCount <= divCount + 8'h02;
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          link.synthClocks[g] <= 1'b0;
        end else begin
          link.synthClocks[g] <= level;
        end
      end
    end
  endgenerate
endmodule

// File: rtl/pll_synth_pkg.sv
// shared constants and types for the clock synthesizer model and its controller
package pll_synth_pkg;
  localparam int unsigned REF_COUNT       = 4;
  localparam int unsigned SEL_WIDTH       = 2;
  localparam int unsigned OUT_COUNT       = 5;
  localparam int unsigned PHASE_WIDTH     = 3;
  localparam int unsigned CNT_WIDTH       = 8;
  localparam int unsigned PRODUCT_LIMIT   = 255;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RESET_MIN_PS    = 10000;
  localparam int unsigned RESET_MIN_CYC   = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LOCK_WAIT_CYC   = 64;
  localparam int unsigned FIRST_OUT_RATIO = 4;

  localparam logic [7:0] DEF_PRE    = 8'h01;
  localparam logic [7:0] DEF_MULT   = 8'h04;
  localparam logic [7:0] DEF_POST   = 8'h01;
  localparam logic [7:0] DEF_FBK    = 8'h01;
  localparam logic [7:0] DEF_OUTDIV = 8'h04;

  // controller register offsets (APB byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PHASE   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ     = 8'h0C;
  localparam logic [7:0] OFS_MASK    = 8'h10;
  // control fields
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_SEL_LO = 4;
  // phase fields
  localparam int unsigned PH_VAL_LO   = 0;
  localparam int unsigned PH_SEL_LO   = 4;
  localparam int unsigned PH_GO       = 16;
  // interrupt bits
  localparam int unsigned EV_LOCK     = 0;
  localparam int unsigned EV_UNLOCK   = 1;
  localparam int unsigned EV_DONE     = 2;
  localparam int unsigned EV_WIDTH    = 3;

  typedef enum logic [1:0] {
    CTL_IDLE   = 2'b00,
    CTL_RESET  = 2'b01,
    CTL_SHIFT  = 2'b10
  } ctl_state_e;
endpackage
